/* File: logic/ctf_pkg.sv */
/*
 * ctf_pkg: register map, field positions and shared types for the cluster
 * timer and fault register group.
 * Assumes one system clock and an asynchronous active-low cold reset.
 */
package ctf_pkg;

    // register bus geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 64;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_MT_VALUE   = 16'h_8050;
    localparam logic [ADDR_W-1:0] OFS_TIMER_CTL  = 16'h_8058;
    localparam logic [ADDR_W-1:0] OFS_GATER_OVR  = 16'h_8060;
    localparam logic [ADDR_W-1:0] OFS_FAULT_SUM  = 16'h_8068;
    localparam logic [ADDR_W-1:0] OFS_FAULT_CAP  = 16'h_8070;
    localparam logic [ADDR_W-1:0] OFS_HR_VALUE   = 16'h_8090;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 16'h_80A0;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 16'h_80A8;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR  = 16'h_80B0;

    // timer control field positions
    localparam int BIT_MT_HALT = 0;
    localparam int BIT_MT_ARM  = 1;
    localparam int BIT_HR_HALT = 2;
    localparam int BIT_HR_ARM  = 3;
    localparam int CTL_W       = 4;

    // interrupt status layout
    localparam int IRQ_MT_SYNC = 0;
    localparam int IRQ_HR_SYNC = 1;
    localparam int IRQ_FAULT   = 2;
    localparam int IRQ_W       = 3;

    // fault, gater and timer word geometry
    localparam int FAULT_W  = 12;
    localparam int GATER_W  = 32;
    localparam int TIMER_W  = 64;

    // reset values
    localparam logic [CTL_W-1:0]   CTL_RST   = 4'h_0;
    localparam logic [GATER_W-1:0] GATER_RST = 32'h_0000_0000;
    localparam logic [TIMER_W-1:0] TIMER_RST = 64'h_0000_0000_0000_0000;
    localparam logic [DATA_W-1:0]  READ_ZERO = 64'h_0000_0000_0000_0000;

    // register bus request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ctf_req_t;

    // timer control bits as stored
    typedef struct packed {
        logic hr_sync_arm;
        logic hr_halt;
        logic mt_sync_arm;
        logic mt_halt;
    } ctf_ctl_t;

endpackage : ctf_pkg

/* File: logic/ctf_timer.sv */
/*
 * ctf_timer: one 64-bit time counter with halt and a sync restart.
 * Assumes tick and sync are synchronous single-clock inputs.
 */
module ctf_timer
    import ctf_pkg::*;
#(
    parameter int WIDTH = TIMER_W
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             reset_n,
    // control
    input  wire logic             tick,
    input  wire logic             halt,
    input  wire logic             restart,
    // value
    output logic [WIDTH-1:0]      value
);

    initial begin
        if (WIDTH < 2) $error("ctf_timer width too small");
    end

    // counting resumes in the restart cycle itself, so no tick is lost
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            value <= '0;
        end else if (tick && (!halt || restart)) begin
            value <= value + 1'b1;
        end
    end

endmodule : ctf_timer

/* File: logic/ctf_sticky.sv */
/*
 * ctf_sticky: sticky event bits with write-one-to-clear and enable mask.
 * Assumes events are one-cycle or level signals on the system clock.
 */
module ctf_sticky
    import ctf_pkg::*;
#(
    parameter int WIDTH = IRQ_W
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             reset_n,
    // events and software controls
    input  wire logic [WIDTH-1:0] event_in,
    input  wire logic [WIDTH-1:0] clear,
    input  wire logic [WIDTH-1:0] enable,
    // state
    output logic [WIDTH-1:0]      status,
    output logic                  irq
);

    // set wins over a clear in the same cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            status <= '0;
        end else begin
            status <= (status & ~clear) | event_in;
        end
    end

    // level interrupt registered for a clean output
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((status & ~clear) | event_in) & enable);
        end
    end

endmodule : ctf_sticky

/* File: logic/ctf_regs.sv */
/*
 * ctf_regs: cluster timer control, clock gater override and fault summary
 * register group, with machine and high-resolution time counters.
 * Assumes a plain register port (read data one cycle after the strobe),
 * synchronous inputs, one clock and an asynchronous cold reset.
 */
module ctf_regs
    import ctf_pkg::*;
#(
    parameter int                 NUM_DOMAINS              = 4,
    parameter bit                 FUNCTIONAL_SAFETY_OPTION = 1'b1,
    parameter logic [FAULT_W-1:0] FAULT_SUPPORT            = 12'h_FFF
) (
    // clock and reset
    input  wire logic                         clock,
    input  wire logic                         reset_n,
    // register port
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    input  wire logic [ADDR_W-1:0]            reg_addr,
    input  wire logic [DATA_W-1:0]            reg_wdata,
    output logic [DATA_W-1:0]                 reg_rdata,
    // timer ticks and cluster sync pin
    input  wire logic                         mt_tick,
    input  wire logic                         hr_tick,
    input  wire logic                         cluster_sync,
    // fault domain status words
    input  wire logic [NUM_DOMAINS*FAULT_W-1:0] domain_faults,
    // outputs to the cluster
    output logic [GATER_W-1:0]                gater_override_bits,
    output logic [TIMER_W-1:0]                machine_time,
    output logic [TIMER_W-1:0]                hr_time,
    output logic                              irq
);

    initial begin
        if (NUM_DOMAINS < 1) $error("ctf_regs needs at least one fault domain");
    end

    ctf_req_t             req;
    ctf_ctl_t             ctl;
    logic [IRQ_W-1:0]     irq_enable;
    logic [IRQ_W-1:0]     irq_status;
    logic [IRQ_W-1:0]     irq_clear;
    logic [IRQ_W-1:0]     irq_events;
    logic [FAULT_W-1:0]   fault_summary;
    logic [FAULT_W-1:0]   next_fault_summary;
    logic [FAULT_W-1:0]   fault_prev;
    logic                 mt_restart;
    logic                 hr_restart;
    logic                 irq_int;

    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

    // restart only when both halt and arm are set and the pin is high
    assign mt_restart = ctl.mt_halt && ctl.mt_sync_arm && cluster_sync;
    assign hr_restart = ctl.hr_halt && ctl.hr_sync_arm && cluster_sync;

    // timer control: software writes, sync restart clears both bits
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctl <= CTL_RST;
        end else begin
            if (req.wr && req.addr == OFS_TIMER_CTL) begin
                ctl.mt_halt     <= req.wdata[BIT_MT_HALT];
                ctl.mt_sync_arm <= req.wdata[BIT_MT_ARM];
                ctl.hr_halt     <= req.wdata[BIT_HR_HALT];
                ctl.hr_sync_arm <= req.wdata[BIT_HR_ARM];
            end
            // hardware restart wins over a simultaneous software write
            if (mt_restart) begin
                ctl.mt_halt     <= 1'b0;
                ctl.mt_sync_arm <= 1'b0;
            end
            if (hr_restart) begin
                ctl.hr_halt     <= 1'b0;
                ctl.hr_sync_arm <= 1'b0;
            end
        end
    end

    // machine time counter
    ctf_timer #(
        .WIDTH (TIMER_W)
    ) u_mt_timer (
        .clock   (clock),
        .reset_n (reset_n),
        .tick    (mt_tick),
        .halt    (ctl.mt_halt),
        .restart (mt_restart),
        .value   (machine_time)
    );

    // high-resolution time counter
    ctf_timer #(
        .WIDTH (TIMER_W)
    ) u_hr_timer (
        .clock   (clock),
        .reset_n (reset_n),
        .tick    (hr_tick),
        .halt    (ctl.hr_halt),
        .restart (hr_restart),
        .value   (hr_time)
    );

    // clock gater override word
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            gater_override_bits <= GATER_RST;
        end else if (req.wr && req.addr == OFS_GATER_OVR) begin
            gater_override_bits <= req.wdata[GATER_W-1:0];
        end
    end

    // or of all fault domains; forced to zero without the safety option
    always_comb begin
        next_fault_summary = '0;
        for (int d = 0; d < NUM_DOMAINS; d++) begin
            next_fault_summary = next_fault_summary
                               | domain_faults[d*FAULT_W +: FAULT_W];
        end
        if (!FUNCTIONAL_SAFETY_OPTION) begin
            next_fault_summary = '0;
        end
    end

    // registered summary, software cannot write it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fault_summary <= '0;
            fault_prev    <= '0;
        end else begin
            fault_summary <= next_fault_summary;
            fault_prev    <= fault_summary;
        end
    end

    // events: each sync restart and any newly raised fault bit
    assign irq_events[IRQ_MT_SYNC] = mt_restart;
    assign irq_events[IRQ_HR_SYNC] = hr_restart;
    assign irq_events[IRQ_FAULT]   = |(fault_summary & ~fault_prev);

    // interrupt enable mask
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_enable <= '0;
        end else if (req.wr && req.addr == OFS_IRQ_ENABLE) begin
            irq_enable <= req.wdata[IRQ_W-1:0];
        end
    end

    // write-only clear register acts for one cycle
    assign irq_clear = (req.wr && req.addr == OFS_IRQ_CLEAR) ? req.wdata[IRQ_W-1:0] : '0;

    ctf_sticky #(
        .WIDTH (IRQ_W)
    ) u_sticky (
        .clock    (clock),
        .reset_n  (reset_n),
        .event_in (irq_events),
        .clear    (irq_clear),
        .enable   (irq_enable),
        .status   (irq_status),
        .irq      (irq_int)
    );

    assign irq = irq_int;

    // read data one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= READ_ZERO;
        end else if (req.rd) begin
            reg_rdata <= READ_ZERO;
            unique case (req.addr)
                OFS_MT_VALUE:   reg_rdata <= machine_time;
                OFS_TIMER_CTL:  reg_rdata <= {{(DATA_W-CTL_W){1'b0}}, ctl};
                OFS_GATER_OVR:  reg_rdata <= {{(DATA_W-GATER_W){1'b0}}, gater_override_bits};
                OFS_FAULT_SUM:  reg_rdata <= {{(DATA_W-FAULT_W){1'b0}}, fault_summary};
                OFS_FAULT_CAP:  reg_rdata <= FUNCTIONAL_SAFETY_OPTION
                                           ? {{(DATA_W-FAULT_W){1'b0}}, FAULT_SUPPORT}
                                           : READ_ZERO;
                OFS_HR_VALUE:   reg_rdata <= hr_time;
                OFS_IRQ_STATUS: reg_rdata <= {{(DATA_W-IRQ_W){1'b0}}, irq_status};
                OFS_IRQ_ENABLE: reg_rdata <= {{(DATA_W-IRQ_W){1'b0}}, irq_enable};
                default:        reg_rdata <= READ_ZERO;
            endcase
        end
    end

    // halted counter holds its value except in a sync restart cycle
    a_mt_halt_hold: assert property (@(posedge clock) disable iff (!reset_n)
        ctl.mt_halt && !mt_restart |=> $stable(machine_time))
        else $error("machine time moved while halted");

    a_mt_restart_clr: assert property (@(posedge clock) disable iff (!reset_n)
        mt_restart |=> !ctl.mt_halt && !ctl.mt_sync_arm)
        else $error("machine sync restart did not clear bits");

    a_hr_restart_clr: assert property (@(posedge clock) disable iff (!reset_n)
        hr_restart |=> !ctl.hr_halt && !ctl.hr_sync_arm)
        else $error("hr sync restart did not clear bits");

    a_hr_halt_hold: assert property (@(posedge clock) disable iff (!reset_n)
        ctl.hr_halt && !hr_restart |=> $stable(hr_time))
        else $error("hr time moved while halted");

    a_mt_counts: assert property (@(posedge clock) disable iff (!reset_n)
        mt_tick && !ctl.mt_halt |=> machine_time == $past(machine_time) + 64'h_1)
        else $error("machine time did not advance");

    a_ctl_write: assert property (@(posedge clock) disable iff (!reset_n)
        req.wr && req.addr == OFS_TIMER_CTL && !cluster_sync
        |=> ctl == $past(req.wdata[CTL_W-1:0]))
        else $error("timer control write lost");

    a_gater_write: assert property (@(posedge clock) disable iff (!reset_n)
        req.wr && req.addr == OFS_GATER_OVR
        |=> gater_override_bits == $past(req.wdata[GATER_W-1:0]))
        else $error("gater override write lost");

    a_fault_or: assert property (@(posedge clock) disable iff (!reset_n)
        ##1 fault_summary == $past(next_fault_summary))
        else $error("fault summary is not the domain or");

    a_fault_rd_rsvd: assert property (@(posedge clock) disable iff (!reset_n)
        req.rd && req.addr == OFS_FAULT_SUM
        |=> reg_rdata[DATA_W-1:FAULT_W] == '0
            && reg_rdata[FAULT_W-1:0] == $past(fault_summary))
        else $error("fault summary read wrong");

    a_cap_read: assert property (@(posedge clock) disable iff (!reset_n)
        req.rd && req.addr == OFS_FAULT_CAP
        |=> reg_rdata == (FUNCTIONAL_SAFETY_OPTION
            ? {{(DATA_W-FAULT_W){1'b0}}, FAULT_SUPPORT} : READ_ZERO))
        else $error("capability read wrong");

    // unhalted high-resolution counter steps once per tick
    a_hr_counts: assert property (@(posedge clock) disable iff (!reset_n)
        hr_tick && !ctl.hr_halt |=> hr_time == $past(hr_time) + 64'h_1)
        else $error("hr time did not advance");

    // a restart counts in its own cycle, so no tick is lost at resync
    a_mt_restart_go: assert property (@(posedge clock) disable iff (!reset_n)
        mt_restart && mt_tick |=> machine_time == $past(machine_time) + 64'h_1)
        else $error("machine time did not restart");

    a_hr_restart_go: assert property (@(posedge clock) disable iff (!reset_n)
        hr_restart && hr_tick |=> hr_time == $past(hr_time) + 64'h_1)
        else $error("hr time did not restart");

    // arm alone must not be dropped, since restart needs halt as well
    a_mt_arm_keep: assert property (@(posedge clock) disable iff (!reset_n)
        ctl.mt_sync_arm && !ctl.mt_halt && !req.wr |=> ctl.mt_sync_arm)
        else $error("machine arm bit lost");

    a_hr_arm_keep: assert property (@(posedge clock) disable iff (!reset_n)
        ctl.hr_sync_arm && !ctl.hr_halt && !req.wr |=> ctl.hr_sync_arm)
        else $error("hr arm bit lost");

    // halted and armed counters wait for the pin or a timer control write
    a_mt_wait_pin: assert property (@(posedge clock) disable iff (!reset_n)
        ctl.mt_halt && ctl.mt_sync_arm && !cluster_sync && !req.wr
        |=> ctl.mt_halt && ctl.mt_sync_arm)
        else $error("machine armed halt left without pin");

    a_hr_wait_pin: assert property (@(posedge clock) disable iff (!reset_n)
        ctl.hr_halt && ctl.hr_sync_arm && !cluster_sync && !req.wr
        |=> ctl.hr_halt && ctl.hr_sync_arm)
        else $error("hr armed halt left without pin");

    // read path: each register answers one cycle after the strobe
    a_ctl_read: assert property (@(posedge clock) disable iff (!reset_n)
        req.rd && req.addr == OFS_TIMER_CTL
        |=> reg_rdata == {{(DATA_W-CTL_W){1'b0}}, $past(ctl)})
        else $error("timer control read wrong");

    a_gater_read: assert property (@(posedge clock) disable iff (!reset_n)
        req.rd && req.addr == OFS_GATER_OVR
        |=> reg_rdata == {{(DATA_W-GATER_W){1'b0}}, $past(gater_override_bits)})
        else $error("gater override read wrong");

    a_mt_read: assert property (@(posedge clock) disable iff (!reset_n)
        req.rd && req.addr == OFS_MT_VALUE
        |=> reg_rdata == $past(machine_time))
        else $error("machine time read wrong");

    a_hr_read: assert property (@(posedge clock) disable iff (!reset_n)
        req.rd && req.addr == OFS_HR_VALUE
        |=> reg_rdata == $past(hr_time))
        else $error("hr time read wrong");

    // software writes never reach the summary
    a_sum_ro: assert property (@(posedge clock) disable iff (!reset_n)
        req.wr && req.addr == OFS_FAULT_SUM
        |=> fault_summary == $past(next_fault_summary))
        else $error("fault summary took a write");

    // a newly raised fault bit must reach the sticky status
    a_fault_event: assert property (@(posedge clock) disable iff (!reset_n)
        irq_events[IRQ_FAULT] |=> irq_status[IRQ_FAULT])
        else $error("fault event not recorded");

    a_irq_enable_wr: assert property (@(posedge clock) disable iff (!reset_n)
        req.wr && req.addr == OFS_IRQ_ENABLE
        |=> irq_enable == $past(req.wdata[IRQ_W-1:0]))
        else $error("interrupt enable write lost");

    // sync events are recorded even while masked
    a_mt_sync_event: assert property (@(posedge clock) disable iff (!reset_n)
        mt_restart |=> irq_status[IRQ_MT_SYNC])
        else $error("machine sync event not recorded");

    a_hr_sync_event: assert property (@(posedge clock) disable iff (!reset_n)
        hr_restart |=> irq_status[IRQ_HR_SYNC])
        else $error("hr sync event not recorded");

endmodule : ctf_regs

/* File: sim/ctf_regs_tb.sv */
/*
 * ctf_regs_tb: self-checking bench for the cluster timer and fault register group.
 * Assumes the package offsets, one 100 MHz clock and the designer's default parameters.
 */
module ctf_regs_tb;
    import ctf_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int ND = 4;
    localparam logic [FAULT_W-1:0] CAP = 12'h_0FFF;

    logic                   clock;
    logic                   reset_n;
    logic                   reg_wr;
    logic                   reg_rd;
    logic [ADDR_W-1:0]      reg_addr;
    logic [DATA_W-1:0]      reg_wdata;
    logic [DATA_W-1:0]      reg_rdata;
    logic                   mt_tick;
    logic                   hr_tick;
    logic                   cluster_sync;
    logic [ND*FAULT_W-1:0]  domain_faults;
    logic [GATER_W-1:0]     gater_override_bits;
    logic [TIMER_W-1:0]     machine_time;
    logic [TIMER_W-1:0]     hr_time;
    logic                   irq;
    int                     fails;
    int                     checks;
    integer                 seed;
    logic [63:0]            d;
    logic [63:0]            v;
    logic [FAULT_W-1:0]     orv;

    ctf_regs #(.NUM_DOMAINS(ND), .FUNCTIONAL_SAFETY_OPTION(1'b1), .FAULT_SUPPORT(CAP)) dut (
        .clock(clock), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .mt_tick(mt_tick), .hr_tick(hr_tick), .cluster_sync(cluster_sync),
        .domain_faults(domain_faults), .gater_override_bits(gater_override_bits),
        .machine_time(machine_time), .hr_time(hr_time), .irq(irq));

    // free-running system clock
    always #5 clock = ~clock;

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one-cycle write strobe, released at the edge that takes it
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [63:0] w);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= w;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask : wr

    // read data stands from the read edge until the next read strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [63:0] r);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1 r = reg_rdata;
    endtask : rd

    function automatic logic [63:0] tval(input int i);
        return (i == 0) ? machine_time : hr_time;
    endfunction : tval

    task automatic finish_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    // hang guard: a stuck run counts as a mismatch
    initial begin
        #200us;
        fails++;
        finish_test();
    end

    initial begin
        clock = 1'b0; reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 16'h_0000; reg_wdata = '0; mt_tick = 1'b1; hr_tick = 1'b1;
        cluster_sync = 1'b0; domain_faults = '0; fails = 0; checks = 0;
        seed = 32'hb6b248d8;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;

        // reset values and unmapped space
        rd(OFS_TIMER_CTL, d); chk(d, 64'h_0);
        rd(OFS_GATER_OVR, d); chk(d, 64'h_0);
        rd(OFS_FAULT_SUM, d); chk(d, 64'h_0);
        rd(OFS_FAULT_CAP, d); chk(d, {52'h_0, CAP});
        rd(16'h_8000, d); chk(d, 64'h_0);
        $display("test reset done");

        // control word: four bits writable, upper bits read zero
        wr(OFS_TIMER_CTL, '1);
        rd(OFS_TIMER_CTL, d); chk(d, 64'h_000F);
        wr(OFS_TIMER_CTL, 64'h_0);
        // gater word, random patterns, upper half dropped
        for (int k = 0; k < 4; k++) begin
            v = {$random(seed), $random(seed)};
            wr(OFS_GATER_OVR, v);
            rd(OFS_GATER_OVR, d); chk(d, {32'h_0, v[31:0]});
            chk({32'h_0, gater_override_bits}, {32'h_0, v[31:0]});
        end
        $display("test registers done");

        // each timer: halt holds, halt alone ignores sync, halt+arm restarts
        for (int i = 0; i < 2; i++) begin
            wr(OFS_TIMER_CTL, 64'h_1 << (2 * i));
            repeat (2) @(posedge clock);
            #1 v = tval(i);
            repeat (5) @(posedge clock);
            #1 chk(tval(i), v);
            chk(tval(1 - i) == v, 1'b0);
            @(posedge clock);
            cluster_sync <= 1'b1;
            @(posedge clock);
            cluster_sync <= 1'b0;
            #1 chk(tval(i), v);
            rd(OFS_TIMER_CTL, d); chk(d, 64'h_1 << (2 * i));
            wr(OFS_TIMER_CTL, 64'h_3 << (2 * i));
            rd(OFS_TIMER_CTL, d); chk(d, 64'h_3 << (2 * i));
            chk(tval(i), v);
            @(posedge clock);
            cluster_sync <= 1'b1;
            @(posedge clock);
            cluster_sync <= 1'b0;
            #1 chk(tval(i), v + 64'h_1);
            repeat (4) @(posedge clock);
            #1 chk(tval(i), v + 64'h_5);
            rd(OFS_TIMER_CTL, d); chk(d, 64'h_0);
        end
        $display("test timers done");

        // fault summary: OR of random domain words, one event interrupt
        wr(OFS_IRQ_CLEAR, 64'h_7);
        wr(OFS_IRQ_ENABLE, 64'h_4);
        rd(OFS_IRQ_STATUS, d); chk(d, 64'h_0);
        chk({63'h_0, irq}, 64'h_0);
        orv = '0;
        for (int k = 0; k < ND; k++) begin
            v[FAULT_W-1:0] = FAULT_W'($random(seed)) | (12'h_001 << k);
            domain_faults[k*FAULT_W +: FAULT_W] <= v[FAULT_W-1:0];
            orv = orv | v[FAULT_W-1:0];
        end
        repeat (5) @(posedge clock);
        rd(OFS_FAULT_SUM, d); chk(d, {52'h_0, orv});
        wr(OFS_FAULT_SUM, '1);
        rd(OFS_FAULT_SUM, d); chk(d, {52'h_0, orv});
        wr(OFS_FAULT_CAP, 64'h_0);
        rd(OFS_FAULT_CAP, d); chk(d, {52'h_0, CAP});
        rd(OFS_IRQ_STATUS, d); chk(d, 64'h_4);
        chk({63'h_0, irq}, 64'h_1);
        // mask then clear
        wr(OFS_IRQ_ENABLE, 64'h_0);
        repeat (3) @(posedge clock);
        #1 chk({63'h_0, irq}, 64'h_0);
        wr(OFS_IRQ_CLEAR, 64'h_4);
        wr(OFS_IRQ_ENABLE, 64'h_4);
        repeat (3) @(posedge clock);
        rd(OFS_IRQ_STATUS, d); chk(d, 64'h_0);
        chk({63'h_0, irq}, 64'h_0);
        // a single bit per position, all twelve
        for (int b = 0; b < FAULT_W; b++) begin
            domain_faults <= '0;
            @(posedge clock);
            domain_faults[(b % ND)*FAULT_W + b] <= 1'b1;
            repeat (3) @(posedge clock);
            rd(OFS_FAULT_SUM, d); chk(d, 64'h_1 << b);
        end
        $display("test faults done");
        finish_test();
    end
endmodule : ctf_regs_tb
